// ### inc/rxf_consts.svh
// Constants of the receive framer control register bank.
// Included by the package users; holds definitions only.
`ifndef RXF_CONSTS_SVH
`define RXF_CONSTS_SVH
`define RXF_AW 14
`define RXF_PORT_MSB 13
`define RXF_PORT_LSB 11
`define RXF_IDX_MSB 10
`define RXF_IDX_LSB 2
`define RXF_IDX_HCTL 9'h010
`define RXF_IDX_SUPP 9'h011
`define RXF_IDX_MSEL 9'h012
`define RXF_IDX_SIGC 9'h013
`define RXF_IDX_T1C2 9'h014
`define RXF_IDX_MON 9'h018
`define RXF_PORT_STRIDE 12'h200
`define RXF_RST_VAL 8'h00
`define RXF_MSEL_MASK 8'h1f
`define RXF_SIGC_MASK 8'h17
`define RXF_T1C2_MASK 8'h1f
`define RXF_HC_CRC 7
`define RXF_HC_RST 6
`define RXF_HC_MAP 5
`define RXF_SC_FSA1 4
`define RXF_SC_FF 2
`define RXF_SC_FE 1
`define RXF_SC_IE 0
`define RXF_T1_SLC 4
`define RXF_T1_OOF2 3
`define RXF_T1_OOF1 2
`define RXF_T1_REMOTE_ALARM_INTEGRATE_EN 1
`define RXF_T1_D4RM 0
`define RXF_FDL_MASK 8'h01
`define RXF_RESP_OKAY 2'b00
`define RXF_RESP_DECERR 2'b11
`define RXF_SIG_STABLE_MF 2'd3
`define RXF_OOF_ERRS 3'd2
`define RXF_OOF_WIN4 3'd4
`define RXF_OOF_WIN5 3'd5
`define RXF_OOF_WIN6 3'd6
`define RXF_RAI_WIN 5'd16
`define RXF_RAI_SET_CNT 5'd16
`define RXF_RAI_CLR_CNT 5'd14
`define RXF_CLK_HZ 50000000
`define RXF_RAI_INTEG_MS 200
`define RXF_RAI_TW 24
`endif

// ### inc/rxf_pkg.sv
// Types of the receive framer control register bank.
// Bus state machines for the register slave.
package rxf_pkg;
	typedef enum logic {RXF_W_IDLE = 1'b0, RXF_W_RESP = 1'b1} rxf_wr_e;
	typedef enum logic {RXF_R_IDLE = 1'b0, RXF_R_RESP = 1'b1} rxf_rd_e;
endpackage

// ### hw/rxf_hist.sv
// Sliding history of single-bit events with a count of ones.
// Assumes the caller strobes one sample per event on shift_en.
`timescale 1ns/1ns
module rxf_hist #(
	parameter int DEPTH = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic shift_en,
	input wire logic bit_in,
	input wire logic [$clog2(DEPTH+1)-1:0] win_len,
	output logic [$clog2(DEPTH+1)-1:0] ones
);
	logic [DEPTH-1:0] hist;

	if (DEPTH < 2) begin : g_chk
		$error("rxf_hist: DEPTH below 2");
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hist <= '0;
		end else if (shift_en) begin
			hist <= {hist[DEPTH-2:0], bit_in};
		end
	end

	// Only the newest win_len samples count
	always_comb begin
		ones = '0;
		for (int i = 0; i < DEPTH; i++) begin
			if ((i < int'(win_len)) && hist[i]) begin
				ones = ones + 1'b1;
			end
		end
	end
endmodule

// ### hw/rxf_regs.sv
// Receive framer control registers for up to eight ports, AXI4-Lite slave,
// plus the per-port control logic they steer.
// Assumes line-side strobes are synchronous to aclk and one cycle wide.
// What this block does
// - CRC display bit enables CRC into FIFO
// - HDLC reset bit resets controller, flushes FIFO
// - Device self-clears HDLC reset within two frames
// - Map select: timeslot, or FACILITY_DATA_LINK/Sa bits
// - Five-bit field picks HDLC channel, 0 = 1
// - New channel select applies only after reset
// - Suppress bits drop matching channel bits
// - Monitor select copies chosen channel to readback
// - T1 force ones on flagged channels
// - E1 resync after two errored alignment signals
// - Alternate criteria: also resync on zero TS16
// - Force freeze freezes signaling, overrides enable
// - Freeze enable allows freezing; zero freezes only on force freeze
// - Integration: report after three stable multiframes
// - Control bit enables SLC-96 synchronizer
// - Out-of-frame select: 2/4, 2/5, 2/6
// - RAI: set 16 of 16, clear 14 or fewer
// - RAI integration (ESF only): over 200 ms set and clear
// - Each port own copy, stride 0x800 bytes (0x200 words)
// - D4 alarm select: bit 2 zeros or S-bit
`timescale 1ns/1ns
`include "rxf_consts.svh"
module rxf_regs
	import rxf_pkg::*;
#(
	parameter int NPORT = 8,
	parameter int unsigned RAI_INTEG_CYC = `RXF_RAI_INTEG_MS * (`RXF_CLK_HZ / 1000)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`RXF_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`RXF_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [NPORT-1:0] e1_mode,
	input wire logic [NPORT-1:0] esf_mode,
	input wire logic [NPORT-1:0] frame_pulse,
	input wire logic [NPORT-1:0] ts_strobe,
	input wire logic [NPORT-1:0][4:0] ts_num,
	input wire logic [NPORT-1:0][7:0] ts_data,
	input wire logic [NPORT-1:0] fdl_bit_valid,
	input wire logic [NPORT-1:0] fdl_bit,
	input wire logic [NPORT-1:0] fdl_word_valid,
	input wire logic [NPORT-1:0] fdl_word_00ff,
	input wire logic [NPORT-1:0] mf_pulse,
	input wire logic [NPORT-1:0] sig_changed,
	input wire logic [NPORT-1:0] freeze_req,
	input wire logic [NPORT-1:0] sig_ones_channel_mask,
	input wire logic [NPORT-1:0] mfas_err,
	input wire logic [NPORT-1:0] mfas_ok,
	input wire logic [NPORT-1:0] ts16_zero,
	input wire logic [NPORT-1:0] fbit_valid,
	input wire logic [NPORT-1:0] fbit_err,
	output logic [NPORT-1:0] crc_display_en,
	output logic [NPORT-1:0] hdlc_ctrl_reset,
	output logic [NPORT-1:0] hdlc_strobe,
	output logic [NPORT-1:0][7:0] hdlc_data,
	output logic [NPORT-1:0][7:0] hdlc_mask,
	output logic [NPORT-1:0] sig_force_ones,
	output logic [NPORT-1:0] sig_freeze,
	output logic [NPORT-1:0] sig_report,
	output logic [NPORT-1:0] cas_resync,
	output logic [NPORT-1:0] cas_align_need_one,
	output logic [NPORT-1:0] loop_carrier_sync_en,
	output logic [NPORT-1:0] loss_of_frame,
	output logic [NPORT-1:0] remote_alarm,
	output logic [NPORT-1:0] superframe_alarm_select
);
	rxf_wr_e wr_state;
	rxf_rd_e rd_state;
	logic aw_got;
	logic w_got;
	logic [`RXF_AW-1:0] w_addr;
	logic [7:0] w_byte;
	logic w_lane;
	logic wr_fire;
	logic [2:0] w_port;
	logic [8:0] w_idx;
	logic w_ok;
	logic [2:0] r_port;
	logic [8:0] r_idx;
	logic [7:0] r_byte;
	logic r_ok;
	logic [7:0] hctl [NPORT];
	logic [7:0] supp [NPORT];
	logic [7:0] msel [NPORT];
	logic [7:0] sigc [NPORT];
	logic [7:0] t1c2 [NPORT];
	logic [7:0] mon_data [NPORT];
	logic [4:0] active_ts [NPORT];
	logic [NPORT-1:0] rst_done;

	if (NPORT < 1 || NPORT > 8) begin : g_chk_port
		$error("rxf_regs: NPORT must be 1 to 8");
	end
	if (RAI_INTEG_CYC < 1 || RAI_INTEG_CYC >= (1 << `RXF_RAI_TW)) begin : g_chk_rai
		$error("rxf_regs: RAI_INTEG_CYC out of range");
	end

	assign w_port = w_addr[`RXF_PORT_MSB:`RXF_PORT_LSB];
	assign w_idx = w_addr[`RXF_IDX_MSB:`RXF_IDX_LSB];
	assign wr_fire = (wr_state == RXF_W_IDLE) && aw_got && w_got;

	// Port field in the upper address bits gives each port its own copy
	always_comb begin
		w_ok = 1'b0;
		if (w_addr[1:0] == 2'b00 && int'(w_port) < NPORT) begin
			case (w_idx)
				`RXF_IDX_HCTL, `RXF_IDX_SUPP, `RXF_IDX_MSEL,
				`RXF_IDX_SIGC, `RXF_IDX_T1C2: w_ok = 1'b1;
				default: w_ok = 1'b0;
			endcase
		end
	end

	// Address and data are taken in either order; the response follows both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state <= RXF_W_IDLE;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RXF_RESP_OKAY;
			w_addr <= '0;
			w_byte <= `RXF_RST_VAL;
			w_lane <= 1'b0;
		end else begin
			case (wr_state)
				RXF_W_IDLE: begin
					if (awvalid && awready) begin
						aw_got <= 1'b1;
						w_addr <= awaddr;
					end
					if (wvalid && wready) begin
						w_got <= 1'b1;
						w_byte <= wdata[7:0];
						w_lane <= wstrb[0];
					end
					awready <= !(aw_got || (awvalid && awready));
					wready <= !(w_got || (wvalid && wready));
					if (aw_got && w_got) begin
						wr_state <= RXF_W_RESP;
						aw_got <= 1'b0;
						w_got <= 1'b0;
						awready <= 1'b0;
						wready <= 1'b0;
						bvalid <= 1'b1;
						bresp <= w_ok ? `RXF_RESP_OKAY : `RXF_RESP_DECERR;
					end
				end
				RXF_W_RESP: begin
					if (bready) begin
						wr_state <= RXF_W_IDLE;
						bvalid <= 1'b0;
						awready <= 1'b1;
						wready <= 1'b1;
					end
				end
				default: wr_state <= RXF_W_IDLE;
			endcase
		end
	end

	assign r_port = araddr[`RXF_PORT_MSB:`RXF_PORT_LSB];
	assign r_idx = araddr[`RXF_IDX_MSB:`RXF_IDX_LSB];

	always_comb begin
		r_byte = `RXF_RST_VAL;
		r_ok = 1'b0;
		if (araddr[1:0] == 2'b00 && int'(r_port) < NPORT) begin
			r_ok = 1'b1;
			case (r_idx)
				`RXF_IDX_HCTL: r_byte = hctl[r_port];
				`RXF_IDX_SUPP: r_byte = supp[r_port];
				`RXF_IDX_MSEL: r_byte = msel[r_port];
				`RXF_IDX_SIGC: r_byte = sigc[r_port];
				`RXF_IDX_T1C2: r_byte = t1c2[r_port];
				`RXF_IDX_MON: r_byte = mon_data[r_port];
				default: r_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= RXF_R_IDLE;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `RXF_RESP_OKAY;
		end else begin
			case (rd_state)
				RXF_R_IDLE: begin
					arready <= 1'b1;
					if (arvalid && arready) begin
						rd_state <= RXF_R_RESP;
						arready <= 1'b0;
						rvalid <= 1'b1;
						rdata <= {24'h000000, r_byte};
						rresp <= r_ok ? `RXF_RESP_OKAY : `RXF_RESP_DECERR;
					end
				end
				RXF_R_RESP: begin
					if (rready) begin
						rd_state <= RXF_R_IDLE;
						rvalid <= 1'b0;
						arready <= 1'b1;
					end
				end
				default: rd_state <= RXF_R_IDLE;
			endcase
		end
	end

	for (genvar p = 0; p < NPORT; p++) begin : g_port
		logic wr_me;
		logic [2:0] oof_win;
		logic [2:0] oof_ones;
		logic [4:0] rai_ones;
		logic rai_raw;
		logic cas_err_seen;
		logic sig_pend;
		logic [1:0] sig_cnt;
		logic [`RXF_RAI_TW-1:0] rai_tmr;

		// A refused write answers DECERR and must leave every register untouched
		assign wr_me = wr_fire && w_ok && w_lane && (w_port == 3'(p));
		// Done only at a frame boundary seen after the reset was driven out
		assign rst_done[p] = hctl[p][`RXF_HC_RST] && hdlc_ctrl_reset[p] && frame_pulse[p];

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				hctl[p] <= `RXF_RST_VAL;
				supp[p] <= `RXF_RST_VAL;
				msel[p] <= `RXF_RST_VAL;
				sigc[p] <= `RXF_RST_VAL;
				t1c2[p] <= `RXF_RST_VAL;
			end else begin
				if (wr_me && w_idx == `RXF_IDX_HCTL) begin
					// A zero never cancels a pending reset; a one keeps it pending, or starts a new one at the boundary that ends it
					hctl[p] <= {w_byte[7],
						(hctl[p][`RXF_HC_RST] && !rst_done[p]) || w_byte[`RXF_HC_RST],
						w_byte[5:0]};
				end else if (rst_done[p]) begin
					hctl[p][`RXF_HC_RST] <= 1'b0;
				end
				if (wr_me && w_idx == `RXF_IDX_SUPP) begin
					supp[p] <= w_byte;
				end
				if (wr_me && w_idx == `RXF_IDX_MSEL) begin
					msel[p] <= w_byte & `RXF_MSEL_MASK;
				end
				if (wr_me && w_idx == `RXF_IDX_SIGC) begin
					sigc[p] <= w_byte & `RXF_SIGC_MASK;
				end
				if (wr_me && w_idx == `RXF_IDX_T1C2) begin
					t1c2[p] <= w_byte & `RXF_T1C2_MASK;
				end
			end
		end

		// HDLC reset engine and channel latch
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				hdlc_ctrl_reset[p] <= 1'b0;
				active_ts[p] <= 5'h00;
				crc_display_en[p] <= 1'b0;
			end else begin
				hdlc_ctrl_reset[p] <= hctl[p][`RXF_HC_RST] && !rst_done[p];
				if (rst_done[p]) begin
					active_ts[p] <= hctl[p][4:0];
				end
				crc_display_en[p] <= hctl[p][`RXF_HC_CRC];
			end
		end

		// Feed to the HDLC receiver; held off while it is being reset
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				hdlc_strobe[p] <= 1'b0;
				hdlc_data[p] <= 8'h00;
				hdlc_mask[p] <= 8'h00;
			end else begin
				hdlc_strobe[p] <= 1'b0;
				if (hctl[p][`RXF_HC_RST]) begin
					hdlc_strobe[p] <= 1'b0;
				end else if (hctl[p][`RXF_HC_MAP]) begin
					if (fdl_bit_valid[p]) begin
						hdlc_strobe[p] <= 1'b1;
						hdlc_data[p] <= {7'h00, fdl_bit[p]};
						hdlc_mask[p] <= `RXF_FDL_MASK;
					end
				end else if (ts_strobe[p] && ts_num[p] == active_ts[p]) begin
					hdlc_strobe[p] <= 1'b1;
					hdlc_data[p] <= ts_data[p];
					hdlc_mask[p] <= ~supp[p];
				end
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				mon_data[p] <= 8'h00;
			end else if (ts_strobe[p] && ts_num[p] == msel[p][4:0]) begin
				mon_data[p] <= ts_data[p];
			end
		end

		// Signaling: force ones, freeze and change reporting
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				sig_force_ones[p] <= 1'b0;
				sig_freeze[p] <= 1'b0;
				sig_report[p] <= 1'b0;
				sig_pend <= 1'b0;
				sig_cnt <= 2'd0;
			end else begin
				sig_force_ones[p] <= !e1_mode[p] && sigc[p][`RXF_SC_FSA1]
					&& sig_ones_channel_mask[p];
				sig_freeze[p] <= sigc[p][`RXF_SC_FF]
					|| (sigc[p][`RXF_SC_FE] && freeze_req[p]);
				sig_report[p] <= 1'b0;
				if (mf_pulse[p]) begin
					if (sig_changed[p]) begin
						if (sigc[p][`RXF_SC_IE]) begin
							sig_pend <= 1'b1;
							sig_cnt <= 2'd0;
						end else begin
							sig_report[p] <= 1'b1;
							sig_pend <= 1'b0;
						end
					end else if (sig_pend) begin
						sig_cnt <= sig_cnt + 2'd1;
						if (sig_cnt + 2'd1 == `RXF_SIG_STABLE_MF) begin
							sig_report[p] <= 1'b1;
							sig_pend <= 1'b0;
						end
					end
				end
			end
		end

		// E1 CAS multiframe resync criteria
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cas_resync[p] <= 1'b0;
				cas_err_seen <= 1'b0;
				cas_align_need_one[p] <= 1'b0;
			end else begin
				cas_resync[p] <= 1'b0;
				cas_align_need_one[p] <= e1_mode[p] && sigc[p][`RXF_SC_FSA1];
				if (e1_mode[p] && mfas_err[p]) begin
					cas_err_seen <= !cas_err_seen;
					if (cas_err_seen) begin
						cas_resync[p] <= 1'b1;
					end
				end else if (mfas_ok[p]) begin
					cas_err_seen <= 1'b0;
				end
				if (e1_mode[p] && sigc[p][`RXF_SC_FSA1] && ts16_zero[p]) begin
					cas_resync[p] <= 1'b1;
				end
			end
		end

		always_comb begin
			case (t1c2[p][`RXF_T1_OOF2:`RXF_T1_OOF1])
				2'b00: oof_win = `RXF_OOF_WIN4;
				2'b01: oof_win = `RXF_OOF_WIN5;
				default: oof_win = `RXF_OOF_WIN6;
			endcase
		end

		rxf_hist #(.DEPTH(6)) u_oof (
			.aclk(aclk),
			.aresetn(aresetn),
			.shift_en(fbit_valid[p]),
			.bit_in(fbit_err[p]),
			.win_len(oof_win),
			.ones(oof_ones)
		);

		rxf_hist #(.DEPTH(16)) u_rai (
			.aclk(aclk),
			.aresetn(aresetn),
			.shift_en(fdl_word_valid[p]),
			.bit_in(fdl_word_00ff[p]),
			.win_len(`RXF_RAI_WIN),
			.ones(rai_ones)
		);

		// RAI: raw hysteresis, then optional persistence filter in ESF
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rai_raw <= 1'b0;
				rai_tmr <= '0;
				remote_alarm[p] <= 1'b0;
				loss_of_frame[p] <= 1'b0;
				loop_carrier_sync_en[p] <= 1'b0;
				superframe_alarm_select[p] <= 1'b0;
			end else begin
				loss_of_frame[p] <= oof_ones >= `RXF_OOF_ERRS;
				loop_carrier_sync_en[p] <= t1c2[p][`RXF_T1_SLC];
				superframe_alarm_select[p] <= t1c2[p][`RXF_T1_D4RM];
				if (rai_ones == `RXF_RAI_SET_CNT) begin
					rai_raw <= 1'b1;
				end else if (rai_ones <= `RXF_RAI_CLR_CNT) begin
					rai_raw <= 1'b0;
				end
				if (t1c2[p][`RXF_T1_REMOTE_ALARM_INTEGRATE_EN] && esf_mode[p]) begin
					if (rai_raw == remote_alarm[p]) begin
						rai_tmr <= '0;
					end else if (rai_tmr == `RXF_RAI_TW'(RAI_INTEG_CYC)) begin
						remote_alarm[p] <= rai_raw;
						rai_tmr <= '0;
					end else begin
						rai_tmr <= rai_tmr + 1'b1;
					end
				end else begin
					remote_alarm[p] <= rai_raw;
					rai_tmr <= '0;
				end
			end
		end
	end
endmodule

// ### verification/rxf_regs_chk.sv
// Concurrent checks on the register bus and on port 0 of the control bank.
// Bound into the register bank; sees its ports only.
`timescale 1ns/1ns
module rxf_regs_chk
	import rxf_pkg::*;
#(
	parameter int NPORT = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [NPORT-1:0] frame_pulse,
	input wire logic [NPORT-1:0] ts_strobe,
	input wire logic [NPORT-1:0] fdl_bit_valid,
	input wire logic [NPORT-1:0] mf_pulse,
	input wire logic [NPORT-1:0] mfas_err,
	input wire logic [NPORT-1:0] ts16_zero,
	input wire logic [NPORT-1:0] e1_mode,
	input wire logic [NPORT-1:0] hdlc_ctrl_reset,
	input wire logic [NPORT-1:0] hdlc_strobe,
	input wire logic [NPORT-1:0] sig_report,
	input wire logic [NPORT-1:0] cas_resync
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response missing");
	a_write_quiet: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	a_ready_back: assert property (bvalid && bready |=> awready && wready)
		else $error("write channels not reopened");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	a_read_block: assert property (rvalid |-> !arready)
		else $error("read accepted while data pending");
	a_reset_feed: assert property (hdlc_ctrl_reset[0] |-> !hdlc_strobe[0])
		else $error("hdlc fed during reset");
	a_reset_done: assert property (hdlc_ctrl_reset[0] && frame_pulse[0] |=> !hdlc_ctrl_reset[0])
		else $error("hdlc reset outlived frame");
	a_report_cause: assert property (sig_report[0] |-> $past(mf_pulse[0]))
		else $error("signaling report without multiframe");
	a_resync_cause: assert property (cas_resync[0] |-> $past(e1_mode[0] && (mfas_err[0] || ts16_zero[0])))
		else $error("resync without cause");
	a_feed_cause: assert property (hdlc_strobe[0] |-> $past(ts_strobe[0] || fdl_bit_valid[0]))
		else $error("hdlc strobe without source");
	c_reset_done: cover property (hdlc_ctrl_reset[0] ##1 !hdlc_ctrl_reset[0]);
	c_resync: cover property (cas_resync[0]);
	c_report: cover property (sig_report[0]);
endmodule

bind rxf_regs rxf_regs_chk #(.NPORT(NPORT)) chk_u (.*);

// ### verification/rxf_line_model.sv
// Line-side model: one timeslot octet every fourth cycle, 32 slots a frame.
// Assumes the bench drives the remaining line events itself.
`timescale 1ns/1ns
module rxf_line_model
	import rxf_pkg::*;
#(
	parameter int NPORT = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic [NPORT-1:0] frame_pulse,
	output logic [NPORT-1:0] ts_strobe,
	output logic [NPORT-1:0][4:0] ts_num,
	output logic [NPORT-1:0][7:0] ts_data
);
	logic [6:0] cnt;
	logic [7:0] oct;
	always_ff @(posedge aclk) begin
		if (!aresetn) cnt <= '0;
		else cnt <= cnt + 7'h01;
	end
	// Octet tied to its slot so the bench can predict it; slot 0 is channel 1
	assign oct = {3'h0, cnt[6:2]} ^ 8'ha5;
	assign ts_strobe = {NPORT{cnt[1:0] == 2'h3}};
	assign frame_pulse = {NPORT{cnt == 7'h7f}};
	assign ts_num = {NPORT{cnt[6:2]}};
	// Between strobes the data is inverted, never held
	assign ts_data = {NPORT{cnt[1:0] == 2'h3 ? oct : ~oct}};
endmodule

// ### verification/rx_framer_control_regs_tb_top.sv
// Self-checking bench for the receive framer control register bank.
// Assumes the line model supplies timeslots and frame marks; events come from here.
`timescale 1ns/1ns
module rx_framer_control_regs_tb_top
	import rxf_pkg::*;
;
	typedef struct packed {logic [13:0] a; logic [7:0] d, q; logic [1:0] br, rr;} rxf_row_s;
	rxf_row_s rows [8] = '{'{14'h0040, 8'h9f, 8'h9f, 2'h0, 2'h0},
		'{14'h0044, 8'hff, 8'hff, 2'h0, 2'h0}, '{14'h0048, 8'hff, 8'h1f, 2'h0, 2'h0},
		'{14'h004c, 8'hff, 8'h17, 2'h0, 2'h0}, '{14'h0050, 8'hff, 8'h1f, 2'h0, 2'h0},
		'{14'h3850, 8'h0a, 8'h0a, 2'h0, 2'h0}, '{14'h0054, 8'h5a, 8'h00, 2'h3, 2'h3},
		'{14'h0041, 8'h5a, 8'h00, 2'h3, 2'h3}};
	logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0;
	logic rready = '0, lvl = '0, e1 = '0, esf = '0, fr = '0, om = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [13:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, r;
	logic [7:0] v;
	logic [5:0] ev = '0;
	logic [7:0] e1_mode, esf_mode, frame_pulse, ts_strobe, fdl_bit_valid, fdl_bit, fdl_word_valid;
	logic [7:0] fdl_word_00ff, mf_pulse, sig_changed, freeze_req, sig_ones_channel_mask, mfas_err;
	logic [7:0] mfas_ok, ts16_zero, fbit_valid, fbit_err, crc_display_en, hdlc_ctrl_reset;
	logic [7:0] hdlc_strobe, sig_force_ones, sig_freeze, sig_report, cas_resync, cas_align_need_one;
	logic [7:0] loop_carrier_sync_en, loss_of_frame, remote_alarm, superframe_alarm_select;
	logic [7:0][4:0] ts_num;
	logic [7:0][7:0] ts_data, hdlc_data, hdlc_mask;
	int miscompares = 0, comparisons = 0;
	time t0;
	assign e1_mode = {8{e1}};
	assign esf_mode = {8{esf}};
	assign freeze_req = {8{fr}};
	assign sig_ones_channel_mask = {8{om}};
	assign sig_changed = {8{lvl}};
	assign fbit_err = {8{lvl}};
	assign fdl_word_00ff = {8{lvl}};
	assign fdl_bit = 8'hff;
	assign mfas_ok = {8{ev[2] && lvl}};
	assign mf_pulse = {8{ev[0]}};
	assign mfas_err = {8{ev[1]}};
	assign ts16_zero = {8{ev[2]}};
	assign fbit_valid = {8{ev[3]}};
	assign fdl_bit_valid = {8{ev[4]}};
	assign fdl_word_valid = {8{ev[5]}};
	rxf_regs #(.NPORT(8), .RAI_INTEG_CYC(50)) dut_u (.*);
	rxf_line_model #(.NPORT(8)) line_u (.*);
	always #10 aclk = ~aclk;
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [13:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask
	task rd(input logic [13:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		v = rdata[7:0];
		r = rresp;
		rready <= 1'h0;
	endtask
	task ws(input logic [13:0] a, input logic [7:0] d);
		wr(a, d);
		repeat (3) @(posedge aclk);
	endtask
	task strobe(input logic [5:0] e, input logic l);
		@(posedge aclk);
		ev <= e;
		lvl <= l;
		@(posedge aclk);
		ev <= '0;
		#1;
	endtask
	task pause(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk("bresp", rows[i].br, r);
			rd(rows[i].a);
			chk("rresp", rows[i].rr, r);
			chk("rdata", rows[i].q, v);
		end
		chk("crc display", 8'h01, crc_display_en);
		chk("slc sync", 8'h01, loop_carrier_sync_en);
		chk("d4 alarm", 8'h01, superframe_alarm_select);
		@(posedge aclk iff hdlc_strobe[0]);
		chk("old channel", 8'ha5, hdlc_data[0]);
		chk("full suppress", 8'h00, hdlc_mask[0]);
		@(posedge aclk iff frame_pulse[0]);
		t0 = $time;
		wr(14'h40, 8'h5f);
		rd(14'h40);
		chk("reset pending", 8'h5f, v);
		chk("reset out", 8'h01, hdlc_ctrl_reset[0]);
		wr(14'h40, 8'h1f);
		rd(14'h40);
		chk("zero write", 8'h5f, v);
		while (hdlc_ctrl_reset[0] === 1'h1) @(posedge aclk);
		chk("reset time", 8'h01, ($time - t0) < 5120);
		rd(14'h40);
		chk("reset cleared", 8'h1f, v);
		ws(14'h44, 8'h81);
		@(posedge aclk iff hdlc_strobe[0]);
		chk("channel 32", 8'hba, hdlc_data[0]);
		chk("suppress", 8'h7e, hdlc_mask[0]);
		ws(14'h40, 8'h20);
		strobe(6'h10, 1'h0);
		chk("fdl strobe", 8'h01, hdlc_strobe[0]);
		chk("fdl data", 8'h01, hdlc_data[0]);
		chk("fdl mask", 8'h01, hdlc_mask[0]);
		ws(14'h48, 8'h0b);
		pause(140);
		rd(14'h60);
		chk("monitor", 8'hae, v);
		ws(14'h4c, 8'h00);
		strobe(6'h01, 1'h1);
		chk("report", 8'h01, sig_report[0]);
		ws(14'h4c, 8'h01);
		for (int i = 0; i < 4; i++) begin
			strobe(6'h01, i == 0);
			chk("integrated", i == 3, sig_report[0]);
		end
		@(posedge aclk);
		fr <= 1'h1;
		ws(14'h4c, 8'h00);
		chk("no freeze", 8'h00, sig_freeze[0]);
		ws(14'h4c, 8'h02);
		chk("freeze", 8'h01, sig_freeze[0]);
		@(posedge aclk);
		fr <= 1'h0;
		ws(14'h4c, 8'h04);
		chk("forced freeze", 8'h01, sig_freeze[0]);
		@(posedge aclk);
		om <= 1'h1;
		ws(14'h4c, 8'h10);
		chk("ones", 8'h01, sig_force_ones[0]);
		@(posedge aclk);
		om <= 1'h0;
		pause(3);
		chk("ones unflagged", 8'h00, sig_force_ones[0]);
		@(posedge aclk);
		e1 <= 1'h1;
		ws(14'h4c, 8'h00);
		strobe(6'h02, 1'h0);
		strobe(6'h04, 1'h1);
		strobe(6'h02, 1'h0);
		chk("one error", 8'h00, cas_resync[0]);
		strobe(6'h02, 1'h0);
		chk("two errors", 8'h01, cas_resync[0]);
		strobe(6'h04, 1'h0);
		chk("ts16 ignored", 8'h00, cas_resync[0]);
		ws(14'h4c, 8'h10);
		chk("align one", 8'h01, cas_align_need_one[0]);
		strobe(6'h04, 1'h0);
		chk("ts16 resync", 8'h01, cas_resync[0]);
		@(posedge aclk);
		e1 <= 1'h0;
		for (int c = 0; c < 4; c++) begin
			for (int g = 0; g < 2; g++) begin
				ws(14'h50, 8'(c * 4));
				repeat (6) strobe(6'h08, 1'h0);
				strobe(6'h08, 1'h1);
				repeat (g + (c == 0 ? 2 : c == 1 ? 3 : 4)) strobe(6'h08, 1'h0);
				strobe(6'h08, 1'h1);
				pause(2);
				chk("frame loss", g == 0, loss_of_frame[0]);
			end
		end
		ws(14'h50, 8'h00);
		repeat (15) strobe(6'h20, 1'h1);
		pause(3);
		chk("rai early", 8'h00, remote_alarm[0]);
		strobe(6'h20, 1'h1);
		pause(3);
		chk("rai set", 8'h01, remote_alarm[0]);
		strobe(6'h20, 1'h0);
		pause(3);
		chk("rai held", 8'h01, remote_alarm[0]);
		strobe(6'h20, 1'h0);
		pause(3);
		chk("rai clear", 8'h00, remote_alarm[0]);
		@(posedge aclk);
		esf <= 1'h1;
		ws(14'h50, 8'h02);
		repeat (16) strobe(6'h20, 1'h1);
		pause(20);
		chk("rai integrating", 8'h00, remote_alarm[0]);
		pause(60);
		chk("rai integrated", 8'h01, remote_alarm[0]);
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 5; i++) begin
			rd(14'(14'h40 + 4 * i));
			chk("reset value", 8'h00, v);
		end
		chk("crc after reset", 8'h00, crc_display_en[0]);
		stop_test();
	end
endmodule
